// ---- src/exc_pkg.sv ----
// Constants and carrier types for the exception-processing unit.
// Assumes a single core clock and 32-bit longword bus transfers.
package exc_pkg;
	// Status word layout
	typedef struct packed {
		logic       trace_bit;
		logic       rsv14;
		logic       supervisor_bit;
		logic       master_state_bit;
		logic       rsv11;
		logic [2:0] interrupt_priority_mask;
		logic [7:0] ccr;
	} status_word_t;

	// One longword bus request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        write;
		logic        vector_acknowledge_cycle;
	} bus_req_t;

	// Exception sources sampled in the run state
	typedef struct packed {
		logic       debug;
		logic       trap;
		logic [3:0] trap_num;
		logic       op_div;
		logic       op_mac;
		logic       op_enhanced_multiply_accumulate_unit;
		logic       op_unsupported;
		logic       access_error;
		logic       irq;
		logic       exception_return;
	} exc_req_t;

	localparam logic [15:0] SR_RESET        = 16'h2700;
	localparam logic [2:0]  IPL_MAX         = 3'h7;
	localparam logic [31:0] VBR_RESET       = 32'h0000_0000;
	localparam logic [31:0] RESET_SP_ADDR   = 32'h0000_0000;
	localparam logic [31:0] RESET_PC_ADDR   = 32'h0000_0004;
	localparam logic [31:0] LONG_BYTES      = 32'h0000_0004;
	localparam logic [31:0] FRAME_BYTES     = 32'h0000_0008;
	localparam logic [3:0]  FRAME_FORMAT    = 4'h4;
	localparam int          FMT_MSB         = 31;
	localparam int          FMT_LSB         = 28;
	localparam int          VEC_LSB         = 18;
	localparam logic [7:0]  VEC_ACCESS      = 8'h02;
	localparam logic [7:0]  VEC_FORMAT      = 8'h0E;
	localparam logic [7:0]  VEC_DEBUG       = 8'h0C;
	localparam logic [7:0]  VEC_TRAP_BASE   = 8'h20;
	localparam logic [7:0]  VEC_UNSUPPORTED = 8'h3D;
	// Processor family code: arbitrary value
	localparam logic [7:0]  CFG_FAMILY      = 8'h5A;
	localparam logic [3:0]  CFG_VERSION     = 4'h1;
	localparam logic [3:0]  CFG_REVISION    = 4'h0;
	// Presence bits 15 to 11; a set divider bit means no divider
	localparam logic [4:0]  CFG_UNITS       = 5'h08;
	localparam logic [3:0]  CFG_ISA         = 4'h2;
	localparam logic [3:0]  CFG_DEBUG       = 4'h9;
	localparam logic [3:0]  CFG_FLASH_SIZE  = 4'h0;
	localparam logic [3:0]  CFG_SRAM_SIZE   = 4'h5;
endpackage : exc_pkg

// ---- src/exc_vector_select.sv ----
// Prioritises pending exception sources and forms the vector number.
// Assumes requests are same-clock levels held until taken.
`timescale 1ns/1ps
`default_nettype none
module exc_vector_select (
	input  wire exc_pkg::exc_req_t i_req,
	input  wire logic [7:0]        i_irq_vector,
	output logic                   o_any,
	output logic                   o_use_next_pc,
	output logic [7:0]             o_vector
);
	wire unsup = i_req.op_div | i_req.op_mac | i_req.op_enhanced_multiply_accumulate_unit
		| i_req.op_unsupported;
	wire [7:0] trap_vec = exc_pkg::VEC_TRAP_BASE + {4'h0, i_req.trap_num};

	assign o_any = i_req.access_error | unsup | i_req.trap | i_req.debug | i_req.irq;
	assign o_use_next_pc = !(i_req.access_error | unsup);
	assign o_vector = i_req.access_error ? exc_pkg::VEC_ACCESS
		: unsup        ? exc_pkg::VEC_UNSUPPORTED
		: i_req.trap   ? trap_vec
		: i_req.debug  ? exc_pkg::VEC_DEBUG
		: i_irq_vector;
endmodule : exc_vector_select
`default_nettype wire

// ---- src/exc_bus_port.sv ----
// Holds one longword request on the system bus until it completes.
// Assumes the bus answers every request with exactly one done pulse.
`timescale 1ns/1ps
`default_nettype none
module exc_bus_port (
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	input  wire logic              i_launch,
	input  wire exc_pkg::bus_req_t i_req,
	input  wire logic              i_bus_done,
	output logic                   o_bus_req,
	output exc_pkg::bus_req_t      o_bus,
	output logic                   o_done
);
	logic              busy_q;
	exc_pkg::bus_req_t req_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			busy_q <= 1'b0;
		else if (i_launch)
			busy_q <= 1'b1;
		else if (i_bus_done)
			busy_q <= 1'b0;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			req_q <= '0;
		else if (i_launch)
			req_q <= i_req;
	end

	assign o_bus_req = busy_q;
	assign o_bus     = req_q;
	assign o_done    = busy_q & i_bus_done;
endmodule : exc_bus_port
`default_nettype wire

// ---- src/exc_unit.sv ----
// Exception sequencer: reset entry, exception stacking, return, fault-on-fault.
// Assumes the pipeline holds requests until o_taken and the bus answers in order.
`timescale 1ns/1ps
`default_nettype none
//Behaviour
//- Debug interrupt uses vector 12 internally, no acknowledge, mask and master kept.
//- Return format error: address reset, or exception when reset is disabled.
//- Return checks 4-bit frame format; only 4 to 7 are valid.
//- Format-error frame goes below the old one, saving the return's address.
//- Valid return: reload status, read second longword, adjust stack, jump.
//- All 16 trap instructions always raise an exception, entering supervisor.
//- Valid instruction lacking hardware raises the unsupported-instruction exception.
//- Divide, multiply-accumulate and enhanced multiply-accumulate opcodes are unsupported here.
//- Interrupt vector comes from acknowledge cycle or preset number, per enable bit.
//- Fault-on-fault: address reset, or halt when reset is disabled.
//- A fault during fault processing halts until reset.
//- Reset has top priority and aborts everything unrecoverably.
//- Reset sets supervisor, clears trace and master, mask to 7.
//- Reset clears vector base and disables local memory control.
//- After reset read stack pointer at 0, program counter at 4, then fetch.
//- Fault before first instruction completes enters fault-on-fault.
//- Configuration words load into two data registers right after reset.
//- Core word: no optional units, instruction set 0010, debug 1001.
//- Memory word: flash size bits 23-20, SRAM size bits 7-4 = 0101.
module exc_unit (
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	input  wire logic              i_address_reset_disable,
	input  wire logic              i_interrupt_ack_enable,
	input  wire exc_pkg::exc_req_t i_req,
	input  wire logic [2:0]        i_irq_level,
	input  wire logic [7:0]        i_irq_vector,
	input  wire logic [31:0]       i_instr_pc,
	input  wire logic [31:0]       i_next_pc,
	input  wire logic              i_instr_retired,
	input  wire logic              i_bus_done,
	input  wire logic              i_bus_fault,
	input  wire logic [31:0]       i_bus_rdata,
	output logic                   o_bus_req,
	output exc_pkg::bus_req_t      o_bus,
	output logic                   o_taken,
	output logic                   o_fetch_start,
	output logic                   o_halted,
	output logic                   o_address_reset,
	output logic                   o_local_mem_disable,
	output exc_pkg::status_word_t  o_status_word,
	output logic [31:0]            o_stack_pointer,
	output logic [31:0]            o_program_counter,
	output logic [31:0]            o_vector_base_register,
	output logic [31:0]            o_core_config_word,
	output logic [31:0]            o_memory_config_word
);
	typedef enum logic [3:0] {
		ST_INIT, ST_RST_SP, ST_RST_PC, ST_RUN, ST_PUSH_PC, ST_PUSH_SR,
		ST_VECTOR_ACKNOWLEDGE_CYCLE, ST_VEC, ST_RTE_SR, ST_RTE_PC, ST_HALT
	} state_t;

	state_t                state_q, state_d;
	exc_pkg::status_word_t sr_q, saved_sr_q;
	logic [31:0]           sp_q, pc_q, vbr_q, frame_pc_q, frame_sr_q;
	logic [7:0]            vec_q;
	logic                  irq_q, debug_q, first_done_q, launched_q;
	logic                  fetch_q, areset_q, halted_q, memdis_q;
	logic [31:0]           cfg0_q, cfg1_q;
	exc_pkg::bus_req_t     req;
	logic                  port_done;

	// Source selection
	logic       any_exc, use_next;
	logic [7:0] sel_vec;
	exc_vector_select u_sel (
		.i_req         (i_req),
		.i_irq_vector  (i_irq_vector),
		.o_any         (any_exc),
		.o_use_next_pc (use_next),
		.o_vector      (sel_vec)
	);

	// Decode of the current state
	wire        in_run     = (state_q == ST_RUN);
	wire        bus_state  = !(state_q inside {ST_INIT, ST_RUN, ST_HALT});
	wire        exc_state  = state_q inside {ST_PUSH_PC, ST_PUSH_SR, ST_VECTOR_ACKNOWLEDGE_CYCLE, ST_VEC};
	wire        rst_state  = state_q inside {ST_RST_SP, ST_RST_PC};
	wire        launch     = bus_state & !launched_q;
	wire        ok_done    = port_done & !i_bus_fault;
	wire [3:0]  rte_fmt    = i_bus_rdata[exc_pkg::FMT_MSB:exc_pkg::FMT_LSB];
	wire        fmt_ok     = rte_fmt inside {4'h4, 4'h5, 4'h6, 4'h7};
	wire        fmt_err    = (state_q == ST_RTE_SR) & ok_done & !fmt_ok;
	wire        fmt_take   = fmt_err & i_address_reset_disable;
	wire        run_fault  = in_run & i_req.access_error & !first_done_q;
	wire        bus_fof    = port_done & i_bus_fault & (exc_state | rst_state
		| state_q inside {ST_RTE_SR, ST_RTE_PC});
	wire        fof        = run_fault | bus_fof | (fmt_err & !i_address_reset_disable);
	wire        take_exc   = in_run & !run_fault & !i_req.exception_return & any_exc;
	wire        take_rte   = in_run & !run_fault & i_req.exception_return;
	// Interrupt wins only when nothing above it is pending
	wire        irq_pick   = i_req.irq & use_next & !i_req.trap & !i_req.debug;
	// Acknowledge comes first so the frame holds the vector really used
	wire        vector_acknowledge_cycle_first = irq_pick & i_interrupt_ack_enable;
	wire [31:0] push_base  = sp_q - exc_pkg::FRAME_BYTES;
	wire [31:0] vec_addr   = vbr_q + {22'h0, vec_q, 2'b00};
	wire [31:0] frame_word = {exc_pkg::FRAME_FORMAT, 2'b00, vec_q, 2'b00, saved_sr_q};

	// Bus request per state
	always_comb
	begin
		req = '0;
		unique case (state_q)
			ST_RST_SP: req.addr = exc_pkg::RESET_SP_ADDR;
			ST_RST_PC: req.addr = exc_pkg::RESET_PC_ADDR;
			ST_PUSH_PC:
			begin
				req.addr  = sp_q - exc_pkg::LONG_BYTES;
				req.wdata = frame_pc_q;
				req.write = 1'b1;
			end
			ST_PUSH_SR:
			begin
				req.addr  = push_base;
				req.wdata = frame_word;
				req.write = 1'b1;
			end
			ST_VECTOR_ACKNOWLEDGE_CYCLE:   req.vector_acknowledge_cycle = 1'b1;
			ST_VEC:    req.addr = vec_addr;
			ST_RTE_SR: req.addr = sp_q;
			ST_RTE_PC: req.addr = sp_q + exc_pkg::LONG_BYTES;
			default:   req = '0;
		endcase
	end

	exc_bus_port u_port (
		.i_ref_clk  (i_ref_clk),
		.i_reset    (i_reset),
		.i_launch   (launch),
		.i_req      (req),
		.i_bus_done (i_bus_done),
		.o_bus_req  (o_bus_req),
		.o_bus      (o_bus),
		.o_done     (port_done)
	);

	// Sequencer
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_INIT:    state_d = ST_RST_SP;
			ST_RST_SP:  if (ok_done) state_d = ST_RST_PC;
			ST_RST_PC:  if (ok_done) state_d = ST_RUN;
			ST_RUN:     if (take_exc) state_d = vector_acknowledge_cycle_first ? ST_VECTOR_ACKNOWLEDGE_CYCLE : ST_PUSH_PC;
				else if (take_rte) state_d = ST_RTE_SR;
			ST_PUSH_PC: if (ok_done) state_d = ST_PUSH_SR;
			ST_PUSH_SR: if (ok_done) state_d = ST_VEC;
			ST_VECTOR_ACKNOWLEDGE_CYCLE:    if (ok_done) state_d = ST_PUSH_PC;
			ST_VEC:     if (ok_done) state_d = ST_RUN;
			ST_RTE_SR:  if (fmt_take) state_d = ST_PUSH_PC;
				else if (ok_done) state_d = ST_RTE_PC;
			ST_RTE_PC:  if (ok_done) state_d = ST_RUN;
			ST_HALT:    state_d = ST_HALT;
		endcase
		if (fof)
			state_d = ST_HALT;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			state_q <= ST_INIT;
		else
			state_q <= state_d;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset | port_done)
			launched_q <= 1'b0;
		else if (launch)
			launched_q <= 1'b1;
	end

	// Status word
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			sr_q <= exc_pkg::SR_RESET;
		else if (take_exc)
		begin
			sr_q.supervisor_bit <= 1'b1;
			sr_q.trace_bit      <= 1'b0;
		end
		else if (state_q == ST_VEC && ok_done && irq_q)
			sr_q.interrupt_priority_mask <= i_irq_level;
		else if (state_q == ST_RTE_SR && ok_done && fmt_ok)
			sr_q <= i_bus_rdata[15:0];
	end

	// Stack pointer
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			sp_q <= '0;
		else if (state_q == ST_RST_SP && ok_done)
			sp_q <= i_bus_rdata;
		else if (state_q == ST_PUSH_SR && ok_done)
			sp_q <= push_base;
		else if (state_q == ST_RTE_PC && ok_done)
			sp_q <= sp_q + exc_pkg::LONG_BYTES + {28'h0, frame_sr_q[31:28]};
	end

	// Program counter
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			pc_q <= '0;
		else if (ok_done && state_q inside {ST_RST_PC, ST_VEC, ST_RTE_PC})
			pc_q <= i_bus_rdata;
	end

	// Frame contents
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			frame_pc_q <= '0;
			frame_sr_q <= '0;
			vec_q      <= '0;
			irq_q      <= 1'b0;
			debug_q    <= 1'b0;
			saved_sr_q <= exc_pkg::SR_RESET;
		end
		else if (take_exc)
		begin
			frame_pc_q <= use_next ? i_next_pc : i_instr_pc;
			vec_q      <= sel_vec;
			irq_q      <= irq_pick;
			debug_q    <= i_req.debug;
			// Old status stacked, so a return restores user mode
			saved_sr_q <= sr_q;
		end
		else if (take_rte)
			frame_pc_q <= i_instr_pc;
		else if (state_q == ST_RTE_SR && ok_done)
		begin
			frame_sr_q <= i_bus_rdata;
			saved_sr_q <= sr_q;
			vec_q      <= exc_pkg::VEC_FORMAT;
			irq_q      <= 1'b0;
			debug_q    <= 1'b0;
		end
		else if (state_q == ST_VECTOR_ACKNOWLEDGE_CYCLE && ok_done)
			vec_q <= i_bus_rdata[7:0];
	end

	// Reset-time registers and flags
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			vbr_q        <= exc_pkg::VBR_RESET;
			memdis_q     <= 1'b1;
			cfg0_q       <= {exc_pkg::CFG_FAMILY, exc_pkg::CFG_VERSION,
				exc_pkg::CFG_REVISION, exc_pkg::CFG_UNITS, 3'h0,
				exc_pkg::CFG_ISA, exc_pkg::CFG_DEBUG};
			cfg1_q       <= {8'h00, exc_pkg::CFG_FLASH_SIZE, 12'h000,
				exc_pkg::CFG_SRAM_SIZE, 4'h0};
			first_done_q <= 1'b0;
		end
		else if (in_run & i_instr_retired)
			first_done_q <= 1'b1;
	end

	// Pulses and halt state
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			fetch_q  <= 1'b0;
			areset_q <= 1'b0;
			halted_q <= 1'b0;
		end
		else
		begin
			fetch_q  <= ok_done & state_q inside {ST_RST_PC, ST_VEC, ST_RTE_PC};
			// Address reset only requested; the system must return i_reset
			areset_q <= fof & !i_address_reset_disable;
			if (fof & i_address_reset_disable)
				halted_q <= 1'b1;
		end
	end

	assign o_taken                = take_exc | take_rte;
	assign o_fetch_start          = fetch_q;
	assign o_halted               = halted_q;
	assign o_address_reset        = areset_q;
	assign o_local_mem_disable    = memdis_q;
	assign o_status_word          = sr_q;
	assign o_stack_pointer        = sp_q;
	assign o_program_counter      = pc_q;
	assign o_vector_base_register = vbr_q;
	assign o_core_config_word     = cfg0_q;
	assign o_memory_config_word   = cfg1_q;

	// Checks
	a_debug_keeps_mask: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(debug_q && state_q == ST_VEC && ok_done) |=> $stable(sr_q.interrupt_priority_mask))
		else $error("debug entry changed mask");
	a_format_reset: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(fmt_err && !i_address_reset_disable) |=> o_address_reset && state_q == ST_HALT)
		else $error("format error without address reset");
	a_format_check: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_q == ST_RTE_SR && ok_done && rte_fmt == 4'h3 && i_address_reset_disable)
		|=> state_q == ST_PUSH_PC && vec_q == exc_pkg::VEC_FORMAT)
		else $error("bad format accepted");
	a_frame_below: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_q == ST_PUSH_SR && ok_done) |=> sp_q == $past(sp_q) - exc_pkg::FRAME_BYTES)
		else $error("frame placement wrong");
	a_trap_super: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(take_exc && i_req.trap) |=> sr_q.supervisor_bit && state_q == ST_PUSH_PC)
		else $error("trap not taken");
	a_vector_acknowledge_cycle_select: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(take_exc && irq_pick && !i_interrupt_ack_enable)
		|=> state_q == ST_PUSH_PC)
		else $error("acknowledge cycle not skipped");
	a_fof_halt: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(fof && i_address_reset_disable) |=> o_halted ##1 o_halted && state_q == ST_HALT)
		else $error("halt not held");
	a_reset_values: assert property (@(posedge i_ref_clk)
		$fell(i_reset) |-> sr_q == exc_pkg::SR_RESET && vbr_q == exc_pkg::VBR_RESET
		&& state_q == ST_INIT)
		else $error("reset values wrong");
	a_reset_fetch: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_q == ST_RST_PC && launch) |=> o_bus.addr == exc_pkg::RESET_PC_ADDR && !o_bus.write)
		else $error("reset vector address wrong");
	a_vector_addr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_q == ST_VEC && launch) |=> o_bus.addr == vbr_q + {22'h0, vec_q, 2'b00})
		else $error("vector address wrong");
	c_reset_entry: cover property (@(posedge i_ref_clk) disable iff (i_reset)
		state_q == ST_RST_PC ##1 state_q == ST_RUN);
	c_rte_good: cover property (@(posedge i_ref_clk) disable iff (i_reset)
		state_q == ST_RTE_PC && ok_done);
	c_irq_vector_acknowledge_cycle: cover property (@(posedge i_ref_clk) disable iff (i_reset)
		state_q == ST_VECTOR_ACKNOWLEDGE_CYCLE && ok_done);
	c_halt: cover property (@(posedge i_ref_clk) disable iff (i_reset) o_halted);
endmodule : exc_unit
`default_nettype wire

// ---- tb/mem_model.sv ----
// Bus partner model: memory, vector table and acknowledge answers.
// Assumes one longword request at a time, held until o_done is seen.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic              i_ref_clk,
	input  wire logic              i_bus_req,
	input  wire exc_pkg::bus_req_t i_bus,
	input  wire logic [3:0]        i_delay,
	input  wire logic              i_fault,
	input  wire logic [7:0]        i_ack_vector,
	output logic                   o_done,
	output logic                   o_fault,
	output logic [31:0]            o_rdata
);
	localparam logic [31:0] FILL = 32'h0000_4000;
	logic [31:0] mem [logic [31:0]];
	logic [31:0] rd_log [$];
	int          wait_cnt = 0;
	int          vector_acknowledge_cycle_cnt = 0;
	initial
	begin
		o_done  = 1'b0;
		o_fault = 1'b0;
		o_rdata = 32'h0000_0000;
	end
	// Idle data inverts every cycle so a late sample never looks valid
	always @(posedge i_ref_clk)
	begin
		o_done  <= 1'b0;
		o_fault <= 1'b0;
		o_rdata <= ~o_rdata;
		if (!i_bus_req || o_done)
			wait_cnt <= 0;
		else if (wait_cnt < int'(i_delay))
			wait_cnt <= wait_cnt + 1;
		else
		begin
			o_done  <= 1'b1;
			o_fault <= i_fault;
			if (i_bus.vector_acknowledge_cycle)
			begin
				o_rdata  <= {24'h00_0000, i_ack_vector};
				vector_acknowledge_cycle_cnt <= vector_acknowledge_cycle_cnt + 1;
			end
			else if (i_bus.write)
				mem[i_bus.addr] = i_bus.wdata;
			else
			begin
				o_rdata <= mem.exists(i_bus.addr) ? mem[i_bus.addr] : i_bus.addr ^ FILL;
				rd_log.push_back(i_bus.addr);
			end
		end
	end
endmodule : mem_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for exc_unit: reset entry, exceptions, returns, halts.
// Assumes mem_model on the bus; unwritten words read as address ^ FILL.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [31:0] FILL = 32'h0000_4000;
	localparam logic [31:0] IPC  = 32'h0000_0600;
	logic                  i_ref_clk = 1'b0;
	logic                  i_reset   = 1'b1;
	logic                  ard       = 1'b0;
	logic                  iae       = 1'b0;
	logic                  retired   = 1'b0;
	logic                  flt       = 1'b0;
	logic [2:0]            lvl       = 3'h0;
	logic [3:0]            dly       = 4'h2;
	exc_pkg::exc_req_t     req       = '0;
	exc_pkg::bus_req_t     bus;
	exc_pkg::status_word_t sr;
	logic                  done, bflt, breq, taken, fetch, halted, areset, lmd;
	logic [31:0]           rdata, sp, pc, vector_base_register, cw0, cw1;
	int                    error_cnt   = 0;
	int                    comparisons = 0;
	int                    cyc         = 0;
	always #20 i_ref_clk = ~i_ref_clk;
	exc_unit dut_u (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_address_reset_disable(ard),
		.i_interrupt_ack_enable(iae), .i_req(req), .i_irq_level(lvl),
		.i_irq_vector(8'h41), .i_instr_pc(IPC), .i_next_pc(IPC + 32'h2),
		.i_instr_retired(retired), .i_bus_done(done), .i_bus_fault(bflt),
		.i_bus_rdata(rdata), .o_bus_req(breq), .o_bus(bus), .o_taken(taken),
		.o_fetch_start(fetch), .o_halted(halted), .o_address_reset(areset),
		.o_local_mem_disable(lmd), .o_status_word(sr), .o_stack_pointer(sp),
		.o_program_counter(pc), .o_vector_base_register(vector_base_register),
		.o_core_config_word(cw0), .o_memory_config_word(cw1));
	mem_model model_u (
		.i_ref_clk(i_ref_clk), .i_bus_req(breq), .i_bus(bus), .i_delay(dly),
		.i_fault(flt), .i_ack_vector(8'h40), .o_done(done), .o_fault(bflt),
		.o_rdata(rdata));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	// Hang guard, far above the fewer than one thousand cycles the run needs
	always @(posedge i_ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end
	// 1 fetch start, 2 address reset, 3 halted
	task automatic expect_ev(input logic [31:0] e);
		logic [31:0] ev;
		ev = 32'h0;
		for (int i = 0; i < 200 && ev == 32'h0; i++)
		begin
			@(posedge i_ref_clk);
			#1;
			if (fetch === 1'b1) ev = 32'h1;
			else if (areset === 1'b1) ev = 32'h2;
			else if (halted === 1'b1) ev = 32'h3;
		end
		check("event", ev, e);
	endtask : expect_ev
	task automatic do_reset(input logic a, input logic f);
		@(posedge i_ref_clk);
		i_reset <= 1'b1;
		ard     <= a;
		flt     <= f;
		req     <= '0;
		repeat (6) @(posedge i_ref_clk);
		model_u.rd_log.delete();
		i_reset <= 1'b0;
		#1;
	endtask : do_reset
	task automatic retire();
		@(posedge i_ref_clk);
		retired <= 1'b1;
		@(posedge i_ref_clk);
		retired <= 1'b0;
	endtask : retire
	// Request held until o_taken, dropped at the accepting edge
	task automatic issue(input exc_pkg::exc_req_t r);
		@(posedge i_ref_clk);
		req <= r;
		#1;
		for (int i = 0; i < 50 && taken !== 1'b1; i++)
		begin
			@(posedge i_ref_clk);
			#1;
		end
		@(posedge i_ref_clk);
		req <= '0;
		#1;
	endtask : issue
	task automatic run_exc(input exc_pkg::exc_req_t r, input logic [7:0] vec,
		input logic [31:0] spc);
		logic [31:0] sp0;
		logic [15:0] sr0;
		sp0 = sp;
		sr0 = sr;
		issue(r);
		expect_ev(32'h1);
		check("sp", sp, sp0 - 32'h8);
		check("stacked pc", model_u.mem[sp0 - 32'h4], spc);
		check("frame", model_u.mem[sp0 - 32'h8], {4'h4, 2'b00, vec, 2'b00, sr0});
		check("status", {16'h0000, sr & 16'hF8FF}, {16'h0000, (sr0 | 16'h2000) & 16'h78FF});
		check("vector addr", model_u.rd_log[$], {22'h00_0000, vec, 2'b00});
		check("handler", pc, {22'h00_0000, vec, 2'b00} ^ FILL);
	endtask : run_exc
	task automatic rte_ok(input logic [3:0] fmt, input logic [15:0] srv);
		logic [31:0]       sp0;
		exc_pkg::exc_req_t r;
		sp0   = sp;
		r     = '0;
		r.exception_return = 1'b1;
		model_u.mem[sp0] = {fmt, 12'h000, srv};
		model_u.mem[sp0 + 32'h4] = 32'h0000_0800;
		issue(r);
		expect_ev(32'h1);
		check("rte status", {16'h0000, sr}, {16'h0000, srv});
		check("rte pc", pc, 32'h0000_0800);
		check("rte sp", sp, sp0 + 32'h4 + {28'h000_0000, fmt});
	endtask : rte_ok
	initial
	begin
		exc_pkg::exc_req_t r;
		logic [31:0]       sp0;
		int                k;
		logic [3:0]        bad [4];
		bad = '{4'h0, 4'h3, 4'h8, 4'hF};
		model_u.mem[32'h0000_0000] = 32'h0000_2000;
		model_u.mem[32'h0000_0004] = 32'h0000_0400;
		do_reset(1'b1, 1'b0);
		check("status", {16'h0000, sr}, 32'h0000_2700);
		check("vbr", vector_base_register, 32'h0000_0000);
		check("mem off", {31'h0, lmd}, 32'h0000_0001);
		check("cfg0", cw0, {exc_pkg::CFG_FAMILY, exc_pkg::CFG_VERSION, exc_pkg::CFG_REVISION, 16'h4029});
		check("cfg0 low", {16'h0000, cw0[15:0]}, 32'h0000_4029);
		check("cfg1", cw1, 32'h0000_0050);
		expect_ev(32'h1);
		check("sp", sp, 32'h0000_2000);
		check("pc", pc, 32'h0000_0400);
		check("sp addr", model_u.rd_log[0], 32'h0000_0000);
		check("pc addr", model_u.rd_log[1], 32'h0000_0004);
		r = '0;
		r.access_error = 1'b1;
		issue(r);
		expect_ev(32'h3);
		issue(r);
		check("halt", {29'h0, halted, breq, taken}, 32'h0000_0004);
		do_reset(1'b0, 1'b0);
		expect_ev(32'h1);
		// Never taken: the pulse comes at once, so watch while the request stands
		@(posedge i_ref_clk);
		req <= r;
		expect_ev(32'h2);
		@(posedge i_ref_clk);
		req <= '0;
		do_reset(1'b1, 1'b1);
		expect_ev(32'h3);
		do_reset(1'b0, 1'b0);
		expect_ev(32'h1);
		retire();
		dly <= 4'h0;
		for (int f = 4; f < 8; f++)
			rte_ok(4'(f), (f == 7) ? 16'h1000 : 16'h2700);
		for (int n = 0; n < 16; n++)
		begin
			r = '0;
			r.trap = 1'b1;
			r.trap_num = 4'(n);
			run_exc(r, 8'h20 + 8'(n), IPC + 32'h2);
		end
		for (int a = 1; a >= 0; a--)
		begin
			@(posedge i_ref_clk);
			iae <= a[0];
			lvl <= a[0] ? 3'h5 : 3'h3;
			dly <= 4'h3;
			k = model_u.vector_acknowledge_cycle_cnt;
			r = '0;
			r.irq = 1'b1;
			run_exc(r, a[0] ? 8'h40 : 8'h41, IPC + 32'h2);
			check("mask", {29'h0, sr.interrupt_priority_mask}, a[0] ? 32'h5 : 32'h3);
			check("acks", 32'(model_u.vector_acknowledge_cycle_cnt - k), 32'(a));
		end
		@(posedge i_ref_clk);
		iae <= 1'b1;
		k = model_u.vector_acknowledge_cycle_cnt;
		r = '0;
		r.debug = 1'b1;
		run_exc(r, 8'h0C, IPC + 32'h2);
		check("dbg mask", {29'h0, sr.interrupt_priority_mask}, 32'h0000_0003);
		check("dbg acks", 32'(model_u.vector_acknowledge_cycle_cnt - k), 32'h0000_0000);
		for (int u = 0; u < 4; u++)
			run_exc(exc_pkg::exc_req_t'(13'h0008 << u), 8'h3D, IPC);
		@(posedge i_ref_clk);
		ard <= 1'b1;
		r = '0;
		r.exception_return = 1'b1;
		foreach (bad[i])
		begin
			sp0 = sp;
			model_u.mem[sp0] = {bad[i], 28'h000_2700};
			run_exc(r, 8'h0E, IPC);
			check("old frame", model_u.mem[sp0], {bad[i], 28'h000_2700});
		end
		@(posedge i_ref_clk);
		ard <= 1'b0;
		model_u.mem[sp] = 32'h1000_2700;
		issue(r);
		expect_ev(32'h2);
		do_reset(1'b1, 1'b0);
		expect_ev(32'h1);
		retire();
		flt <= 1'b1;
		r = '0;
		r.trap = 1'b1;
		issue(r);
		expect_ev(32'h3);
		do_reset(1'b0, 1'b0);
		expect_ev(32'h1);
		retire();
		dly <= 4'h8;
		issue(r);
		repeat (3) @(posedge i_ref_clk);
		#1;
		check("busy", {31'h0, breq}, 32'h0000_0001);
		do_reset(1'b0, 1'b0);
		check("aborted", {31'h0, breq}, 32'h0000_0000);
		expect_ev(32'h1);
		check("restart sp", sp, 32'h0000_2000);
		check("restart pc", pc, 32'h0000_0400);
		test_done();
	end
endmodule : tb
`default_nettype wire
